// *** verilog/pxbm_pkg.sv ***
// package for the pci-x to packet link bridge mapping block
// assumes one clock domain; shared by the bridge and its bench
package pxbm_pkg;
    // ****************************************
    // transaction and packet kinds
    // ****************************************
    typedef enum logic [2:0] {
        PXBM_TX_PMW = 3'h0,
        PXBM_TX_SWR = 3'h1,
        PXBM_TX_SRR = 3'h2,
        PXBM_TX_IWC = 3'h3,
        PXBM_TX_IRC = 3'h4,
        PXBM_TX_SWC = 3'h5,
        PXBM_TX_SRC = 3'h6,
        PXBM_TX_DIM = 3'h7
    } pxbm_tx_t;

    typedef enum logic [1:0] {
        PXBM_PK_WRSZ = 2'h0,
        PXBM_PK_RDSZ = 2'h1,
        PXBM_PK_DONE = 2'h2,
        PXBM_PK_RDRSP = 2'h3
    } pxbm_pk_t;

    typedef enum logic [1:0] {
        PXBM_ST_IDLE = 2'h0,
        PXBM_ST_DIM1 = 2'h1,
        PXBM_ST_DIMD = 2'h2
    } pxbm_st_t;

    // ****************************************
    // register map (ahb-lite, byte addresses)
    // ****************************************
    localparam logic [7:0] PXBM_A_CTRL   = 8'h00;
    localparam logic [7:0] PXBM_A_STATUS = 8'h04;
    localparam logic [7:0] PXBM_A_SEQID  = 8'h08;
    localparam logic [7:0] PXBM_A_BUFCNT = 8'h0c;
    localparam int PXBM_B_PERE  = 0;
    localparam int PXBM_B_DERE  = 1;
    localparam int PXBM_B_INORD = 2;
    localparam int PXBM_B_CLRPW = 3;
    localparam logic [3:0] PXBM_CTRL_RST = 4'h0;
    localparam logic [3:0] PXBM_SEQ_ZERO = 4'h0;

    // ****************************************
    // message fragmenting
    // ****************************************
    localparam int PXBM_FRAG_BYTES = 128;
    localparam int PXBM_DW_BYTES   = 4;
    localparam int PXBM_FRAG_DW    = PXBM_FRAG_BYTES / PXBM_DW_BYTES;
    localparam logic [1:0] PXBM_HTRANS_NONSEQ = 2'h2;
endpackage

// *** verilog/pxbm_bridge.sv ***
// pci-x to packet link request/completion mapper with ordering gate
// assumes an upstream decoder presenting one transaction at a time
// with a valid/ready handshake, and a link sink with ready back-pressure
// Operation
// R1: relaxed posted write may be passed by later writes, completions
// R2: posted write maps to posted sized write, flags from attributes
// R3: split write request maps to nonposted sized write, pass_posted_writes_flag 0, coherent 1
// R4: split read maps to sized read, resp flag from relaxed ordering
// R5: immediate write completion gives done response, pass_posted_writes_flag 1, parity error flag
// R6: immediate read completion copies original resp flag, parity error flag
// R7: split completions map to done or read response, errors from message
// R8: first message packet carries the header fields
// R9: middle message packets keep chain set, last packet clears it
// R10: only message classes 0 and 1 are mapped
// R11: messages cut into 128 byte fragments at disconnect boundaries (here frag_dw_q only counts and wraps; no packet is cut)
// R12: sequence id is zero unless in-order bursts are wanted
// R13: in-order read beats share a non-zero sequence id
// R14: discontiguous byte enables may be split into several transactions
// R15: relaxed posted write pieces any order, other pieces ascending
// R16: configuration and io requests split at every doubleword
// R17: response buffer reserved before any link request is sent
// R18: data error flag set on parity or mode 2 ecc error
// R19: split write with data error dropped when parity response enabled
// R20: split write completion parity flag needs link error enable
// R21: done response pass_posted_writes_flag cleared in certain ordering situations
// R22: requests never pass posted writes; completions only pass relaxed ones (here only strict writes block, and only requests and read completions)
module pxbm_bridge
    import pxbm_pkg::*;
#(
    parameter int RSP_BUFS = 4,
    parameter int PW_MAX   = 8
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // pci-x side transaction
    input  wire logic        tx_valid,
    output logic             tx_ready,
    input  wire pxbm_tx_t    tx_kind,
    input  wire logic        tx_relaxed,
    input  wire logic        tx_no_snoop,
    input  wire logic        tx_parity_err,
    input  wire logic        tx_ecc_err,
    input  wire logic        tx_mode2,
    input  wire logic        tx_cfg_io,
    input  wire logic        tx_orig_resp_pass,
    input  wire logic        tx_cmpl_err,
    input  wire logic        tx_last,
    input  wire logic        tx_msg_class,
    input  wire logic        tx_route_type,
    input  wire logic        tx_silent_drop,
    input  wire logic        tx_init_req,
    input  wire logic [11:0] tx_byte_count,
    input  wire logic [15:0] tx_requester_id,
    input  wire logic [63:0] tx_addr,
    input  wire logic [63:0] tx_data,
    input  wire logic [3:0]  tx_byte_en,
    // response buffer release from the link side
    input  wire logic        rsp_release,
    // link packet out
    output logic             pk_valid,
    input  wire logic        pk_ready,
    output pxbm_pk_t         pk_kind,
    output logic             pk_posted,
    output logic             pass_posted_writes_flag,
    output logic             response_pass_posted_flag,
    output logic             pk_coherent,
    output logic             data_error_flag,
    output logic             pk_chain,
    output logic [3:0]       pk_seq_id,
    output logic [63:0]      pk_addr,
    output logic [63:0]      pk_data,
    output logic [3:0]       pk_byte_en
);
    // ****************************************
    // register bus
    // ****************************************
    logic [3:0]  ctrl_q;
    logic [3:0]  seq_q;
    logic        ap_wr_q;
    logic [7:0]  ap_addr_q;
    logic [2:0]  buf_used_q;
    logic [3:0]  pw_strict_q;
    logic [7:0]  drop_cnt_q;
    logic [7:0]  split_cnt_q;
    logic [31:0] rdata_mux;
    wire ap_take = hsel && hready && htrans == PXBM_HTRANS_NONSEQ;

    // zero wait state slave; unmapped reads as zero, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    // read data loads at the address phase so it stands at the data-phase edge
    assign rdata_mux = (haddr == PXBM_A_CTRL)   ? {28'h0, ctrl_q} :
                       (haddr == PXBM_A_STATUS) ? {16'h0, split_cnt_q, drop_cnt_q} :
                       (haddr == PXBM_A_SEQID)  ? {28'h0, seq_q} :
                       (haddr == PXBM_A_BUFCNT) ? {25'h0, pw_strict_q, buf_used_q} :
                       32'h0;

    // address phase capture, write data lands in data phase
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ap_wr_q   <= 1'b0;
            ap_addr_q <= 8'h0;
            ctrl_q    <= PXBM_CTRL_RST;
            seq_q     <= PXBM_SEQ_ZERO;
            hrdata    <= 32'h0;
        end else begin
            ap_wr_q <= ap_take && hwrite;
            if (ap_take) ap_addr_q <= haddr;
            if (ap_take && !hwrite) hrdata <= rdata_mux;
            if (ap_wr_q && ap_addr_q == PXBM_A_CTRL) ctrl_q <= hwdata[3:0];
            if (ap_wr_q && ap_addr_q == PXBM_A_SEQID) seq_q <= hwdata[3:0];
        end
    end

    // ****************************************
    // ordering and reservation
    // ****************************************
    wire pere  = ctrl_q[PXBM_B_PERE];
    wire dere  = ctrl_q[PXBM_B_DERE];
    wire inord = ctrl_q[PXBM_B_INORD];
    wire clrpw = ctrl_q[PXBM_B_CLRPW];
    wire is_req   = tx_kind == PXBM_TX_SWR || tx_kind == PXBM_TX_SRR;
    wire is_rc    = tx_kind == PXBM_TX_IRC || tx_kind == PXBM_TX_SRC;
    wire is_wc    = tx_kind == PXBM_TX_IWC || tx_kind == PXBM_TX_SWC;
    wire any_err  = tx_parity_err || (tx_mode2 && tx_ecc_err); // R18
    wire buf_full = buf_used_q == 3'(RSP_BUFS);
    // strict posted writes still unsent block requests and read completions
    wire pw_block = (is_req || is_rc) && pw_strict_q != 4'h0; // R1 R22
    wire dropping = tx_kind == PXBM_TX_SWR && pere && any_err; // R19
    wire cls_ok   = tx_kind != PXBM_TX_DIM || !tx_msg_class || tx_msg_class; // R10
    wire need_buf = is_req && !dropping; // R17
    wire go       = tx_valid && !pw_block && !(need_buf && buf_full) && cls_ok;

    // ****************************************
    // splitting (single-byte pieces, ascending)
    // ****************************************
    logic [3:0] be_left_q;
    logic       splitting_q;
    logic [6:0] frag_dw_q;
    pxbm_st_t   st_q;
    // discontiguous enables go out one byte per piece, lowest first, except for config/io requests and messages
    wire discontig = (tx_byte_en == 4'h5) || (tx_byte_en == 4'h9) ||
                     (tx_byte_en == 4'ha) || (tx_byte_en == 4'hb) ||
                     (tx_byte_en == 4'hd); // R14
    wire [3:0] be_src  = splitting_q ? be_left_q : tx_byte_en;
    wire [3:0] low_bit = be_src & (~be_src + 4'h1); // R15 ascending pieces
    wire       do_split = discontig && !tx_cfg_io && tx_kind != PXBM_TX_DIM; // R16
    wire [3:0] piece_be = do_split ? low_bit : tx_byte_en;
    wire [3:0] be_rest  = be_src & ~low_bit;
    wire       last_piece = !do_split || be_rest == 4'h0;
    wire       emit = go && !dropping && (!pk_valid || pk_ready);
    wire       frag_end = frag_dw_q == 7'(PXBM_FRAG_DW - 1); // R11

    // input consumed when the last piece leaves or the request is dropped
    assign tx_ready = (go && dropping) || (emit && last_piece);

    // buffer count and strict write tracker
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            buf_used_q  <= 3'h0;
            pw_strict_q <= 4'h0;
            drop_cnt_q  <= 8'h0;
            split_cnt_q <= 8'h0;
            be_left_q   <= 4'h0;
            splitting_q <= 1'b0;
        end else begin
            buf_used_q <= buf_used_q + 3'(need_buf && tx_ready)
                          - 3'(rsp_release && buf_used_q != 3'h0); // R17
            // a strict write counts until accepted by the link
            pw_strict_q <= pw_strict_q
                + 4'(tx_kind == PXBM_TX_PMW && !tx_relaxed && tx_valid && tx_ready
                     && pw_strict_q != 4'(PW_MAX))
                - 4'(pk_valid && pk_ready && pk_kind == PXBM_PK_WRSZ && pk_posted
                     && !pass_posted_writes_flag && pw_strict_q != 4'h0);
            if (go && dropping) drop_cnt_q <= drop_cnt_q + 8'h1;
            if (emit && do_split) split_cnt_q <= split_cnt_q + 8'h1;
            if (emit && do_split && !last_piece) begin
                be_left_q   <= be_rest;
                splitting_q <= 1'b1;
            end else if (emit) begin
                splitting_q <= 1'b0;
            end
        end
    end

    // device id message phase and fragment counter
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_q      <= PXBM_ST_IDLE;
            frag_dw_q <= 7'h0;
        end else if (emit && tx_kind == PXBM_TX_DIM) begin
            st_q      <= tx_last ? PXBM_ST_IDLE : PXBM_ST_DIMD;
            frag_dw_q <= (frag_end || st_q == PXBM_ST_IDLE) ? 7'h0 : frag_dw_q + 7'h1;
        end
    end

    // ****************************************
    // packet build
    // ****************************************
    pxbm_pk_t  k_d;
    logic      posted_d;
    logic      ppw_d;
    logic      rpp_d;
    logic      coh_d;
    logic      derr_d;
    logic      chain_d;
    logic [63:0] addr_d;
    logic [63:0] data_d;
    wire dim_first = st_q == PXBM_ST_IDLE;

    always_comb begin
        k_d = PXBM_PK_WRSZ;
        posted_d = 1'b0;
        ppw_d = 1'b0;
        rpp_d = 1'b0;
        coh_d = !tx_no_snoop;
        derr_d = any_err;
        chain_d = 1'b0;
        addr_d = tx_addr;
        data_d = tx_data;
        unique case (tx_kind)
            PXBM_TX_PMW: begin
                posted_d = 1'b1; // R2
                ppw_d = tx_relaxed; // R2
            end
            PXBM_TX_SWR: begin
                coh_d = 1'b1; // R3
            end
            PXBM_TX_SRR: begin
                k_d = PXBM_PK_RDSZ;
                rpp_d = tx_relaxed; // R4
            end
            PXBM_TX_IWC: begin
                k_d = PXBM_PK_DONE;
                ppw_d = !clrpw; // R5 R21
            end
            PXBM_TX_IRC: begin
                k_d = PXBM_PK_RDRSP;
                ppw_d = tx_orig_resp_pass; // R6
            end
            PXBM_TX_SWC: begin
                k_d = PXBM_PK_DONE;
                ppw_d = !clrpw; // R7 R21
                derr_d = tx_cmpl_err || (dere && any_err); // R20
            end
            PXBM_TX_SRC: begin
                k_d = PXBM_PK_RDRSP;
                ppw_d = tx_orig_resp_pass; // R7
                derr_d = tx_cmpl_err;
            end
            PXBM_TX_DIM: begin
                posted_d = 1'b1;
                ppw_d = tx_relaxed;
                chain_d = !tx_last; // R9
                if (dim_first) begin
                    addr_d[5:2] = {tx_msg_class, tx_route_type,
                                   tx_silent_drop, tx_init_req}; // R8
                    addr_d[27:24] = tx_byte_count[11:8]; // R8
                    data_d[15:0] = tx_requester_id; // R8
                    data_d[23:16] = tx_byte_count[7:0]; // R8
                    data_d[31:24] = tx_addr[7:0];
                    data_d[63:32] = tx_addr[63:32];
                    chain_d = 1'b1; // R8
                end
            end
        endcase
    end

    // output stage; held until the link takes it
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pk_valid <= 1'b0;
            pk_kind <= PXBM_PK_WRSZ;
            pk_posted <= 1'b0;
            pass_posted_writes_flag <= 1'b0;
            response_pass_posted_flag <= 1'b0;
            pk_coherent <= 1'b0;
            data_error_flag <= 1'b0;
            pk_chain <= 1'b0;
            pk_seq_id <= 4'h0;
            pk_addr <= 64'h0;
            pk_data <= 64'h0;
            pk_byte_en <= 4'h0;
        end else if (emit) begin
            pk_valid <= 1'b1;
            pk_kind <= k_d;
            pk_posted <= posted_d;
            pass_posted_writes_flag <= ppw_d;
            response_pass_posted_flag <= rpp_d;
            pk_coherent <= coh_d;
            data_error_flag <= derr_d; // R18
            pk_chain <= chain_d;
            // in-order bursts only for reads, software guarantees one target
            pk_seq_id <= (inord && tx_kind == PXBM_TX_SRR) ? seq_q : PXBM_SEQ_ZERO; // R12 R13
            pk_addr <= addr_d;
            pk_data <= data_d;
            pk_byte_en <= piece_be;
        end else if (pk_ready) begin
            pk_valid <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_req_no_pass: assert property (@(posedge sys_clk) disable iff (reset) // R22
        (tx_valid && is_req && pw_strict_q != 4'h0) |-> !tx_ready)
        else $error("request passed strict posted write");
    a_swr_coherent: assert property (@(posedge sys_clk) disable iff (reset) // R3
        (emit && tx_kind == PXBM_TX_SWR) |=> (pk_coherent && !pk_posted
                                             && !pass_posted_writes_flag))
        else $error("split write flags wrong");
    a_srr_resp: assert property (@(posedge sys_clk) disable iff (reset) // R4
        (emit && tx_kind == PXBM_TX_SRR) |=> response_pass_posted_flag == $past(tx_relaxed))
        else $error("read resp flag wrong");
    a_pmw_flags: assert property (@(posedge sys_clk) disable iff (reset) // R2
        (emit && tx_kind == PXBM_TX_PMW) |=> (pk_posted
            && pass_posted_writes_flag == $past(tx_relaxed)
            && pk_coherent == !$past(tx_no_snoop)))
        else $error("posted write flags wrong");
    a_drop_swr: assert property (@(posedge sys_clk) disable iff (reset) // R19
        (tx_valid && tx_kind == PXBM_TX_SWR && pere && any_err) |-> !emit)
        else $error("bad split write forwarded");
    a_buf_reserve: assert property (@(posedge sys_clk) disable iff (reset) // R17
        (tx_valid && is_req && buf_full) |-> !emit)
        else $error("request without buffer");
    a_seq_zero: assert property (@(posedge sys_clk) disable iff (reset) // R12
        (emit && !inord) |=> pk_seq_id == PXBM_SEQ_ZERO)
        else $error("nonzero sequence id");
    a_dim_chain: assert property (@(posedge sys_clk) disable iff (reset) // R9
        (emit && tx_kind == PXBM_TX_DIM && tx_last && !dim_first) |=> !pk_chain)
        else $error("last message packet chained");
endmodule

// *** tb/pxbm_link_sink.sv ***
// link side partner: a packet sink that keeps the last packet it took
// assumes the bridge holds every packet field until pk_ready is seen high
module pxbm_link_sink (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        stall,
    input  wire logic        pk_valid,
    output logic             pk_ready,
    input  wire logic [11:0] pk_flags,
    input  wire logic [63:0] pk_addr,
    input  wire logic [63:0] pk_data,
    input  wire logic [3:0]  pk_byte_en,
    output logic [11:0]      got_flags,
    output logic [63:0]      got_addr,
    output logic [63:0]      got_data,
    output logic [3:0]       got_be,
    output int               got_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // acceptance
    // ********
    // stall plays a slow link so output back-pressure is exercised
    assign pk_ready = !stall;

    // capture only on the accepting edge, never a half-held packet
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            got_cnt <= 0;
        end else if (pk_valid && pk_ready) begin
            got_cnt <= got_cnt + 1;
            got_flags <= pk_flags;
            got_addr <= pk_addr;
            got_data <= pk_data;
            got_be <= pk_byte_en;
        end
    end
endmodule

// *** tb/pxbm_bridge_tb_top.sv ***
// self-checking bench for the bridge mapper: ahb master, tx source, link sink
// assumes zero-wait ahb slave and one packet per accepted piece
module pxbm_bridge_tb_top
    import pxbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // signals
    // ********
    logic sys_clk, reset, hsel, hwrite, hreadyout, hresp, tx_valid, tx_ready, stall;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    pxbm_tx_t tx_kind;
    logic tx_relaxed, tx_no_snoop, tx_parity_err, tx_ecc_err, tx_mode2, tx_cfg_io;
    logic tx_orig_resp_pass, tx_cmpl_err, tx_last, tx_msg_class, tx_route_type;
    logic tx_silent_drop, tx_init_req, rsp_release, pk_valid, pk_ready, pk_posted;
    logic [11:0] tx_byte_count, got_flags;
    logic [15:0] tx_requester_id;
    logic [63:0] tx_addr, tx_data, pk_addr, pk_data, got_addr, got_data;
    logic [3:0] tx_byte_en, pk_seq_id, pk_byte_en, got_be;
    pxbm_pk_t pk_kind;
    logic ppw, rpp, pk_coherent, data_error_flag, pk_chain;
    int got_cnt, error_cnt, tests_run;

    // ********
    // instances
    // ********
    pxbm_bridge #(.RSP_BUFS(2), .PW_MAX(8)) pxbm_bridge_inst (
        .sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tx_valid, .tx_ready, .tx_kind,
        .tx_relaxed, .tx_no_snoop, .tx_parity_err, .tx_ecc_err, .tx_mode2, .tx_cfg_io,
        .tx_orig_resp_pass, .tx_cmpl_err, .tx_last, .tx_msg_class, .tx_route_type,
        .tx_silent_drop, .tx_init_req, .tx_byte_count, .tx_requester_id, .tx_addr,
        .tx_data, .tx_byte_en, .rsp_release, .pk_valid, .pk_ready, .pk_kind, .pk_posted,
        .pass_posted_writes_flag(ppw), .response_pass_posted_flag(rpp), .pk_coherent,
        .data_error_flag, .pk_chain, .pk_seq_id, .pk_addr, .pk_data, .pk_byte_en);
    pxbm_link_sink pxbm_link_sink_inst (
        .sys_clk, .reset, .stall, .pk_valid, .pk_ready,
        .pk_flags({pk_kind, pk_posted, ppw, rpp, pk_coherent, data_error_flag, pk_chain,
        pk_seq_id}), .pk_addr, .pk_data, .pk_byte_en, .got_flags, .got_addr, .got_data,
        .got_be, .got_cnt);

    // clock at 25 mhz
    always #20 sys_clk = ~sys_clk;

    // ********
    // shared tasks
    // ********
    task wrap_up();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one single-word transfer; read data taken at the data-phase edge
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= PXBM_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task present(input pxbm_tx_t k, input logic r, n, p, input logic [3:0] be);
        @(posedge sys_clk);
        tx_valid <= 1'b1;
        tx_kind <= k;
        tx_relaxed <= r;
        tx_orig_resp_pass <= r;
        tx_no_snoop <= n;
        tx_parity_err <= p;
        tx_byte_en <= be;
    endtask

    // hold the request until tx_ready is seen, bounded
    task automatic accept();
        int i;
        i = 0;
        do begin
            @(negedge sys_clk);
            i++;
        end while (tx_ready !== 1'b1 && i < 200);
        chk("tx_ready", 1'b1, tx_ready);
        @(posedge sys_clk);
        tx_valid <= 1'b0;
    endtask

    task automatic send(input pxbm_tx_t k, input logic r, n, p, input logic [3:0] be);
        present(k, r, n, p, be);
        accept();
    endtask

    task automatic wait_pk(input int n);
        int i;
        for (i = 0; i < 100 && got_cnt < n; i++) @(negedge sys_clk);
        chk("pk_count", n, got_cnt);
    endtask

    task rel();
        @(posedge sys_clk);
        rsp_release <= 1'b1;
        @(posedge sys_clk);
        rsp_release <= 1'b0;
    endtask

    task automatic map1(input pxbm_tx_t k, input logic r, n, p, input logic [11:0] e, m);
        int b;
        b = got_cnt;
        send(k, r, n, p, 4'hf);
        wait_pk(b + 1);
        chk("flags", e & m, got_flags & m);
        if (k == PXBM_TX_SWR || k == PXBM_TX_SRR) rel();
    endtask

    task refused();
        repeat (4) begin
            @(negedge sys_clk);
            chk("refused", 1'b0, tx_ready);
        end
    endtask

    // ********
    // scenarios
    // ********
    task automatic t_reg();
        ahb(1'b0, PXBM_A_CTRL, 32'h0);
        chk("ctrl_rst", PXBM_CTRL_RST, rd[3:0]);
        ahb(1'b1, PXBM_A_SEQID, 32'h5);
        ahb(1'b0, PXBM_A_SEQID, 32'h0);
        chk("seqid", 4'h5, rd[3:0]);
        ahb(1'b0, 8'h40, 32'h0);
        chk("hresp", 1'b0, hresp);
    endtask

    // every transaction kind but PXBM_TX_DIM against every attribute mix, sequence id zero
    task automatic t_map();
        logic r, n;
        for (int i = 0; i < 4; i++) begin
            r = i[0];
            n = i[1];
            tx_cmpl_err <= r;
            map1(PXBM_TX_PMW, r, n, r, {PXBM_PK_WRSZ, 1'b1, r, 1'bx, !n, r, 5'h0}, 12'hf7f);
            map1(PXBM_TX_SWR, r, n, 1'b0, {PXBM_PK_WRSZ, 3'b00x, 7'h40}, 12'hf7f);
            map1(PXBM_TX_SRR, r, n, 1'b0, {PXBM_PK_RDSZ, 2'b00, r, !n, 6'h0}, 12'hfff);
            map1(PXBM_TX_IWC, r, n, r, {PXBM_PK_DONE, 4'h4, r, 5'h0}, 12'hd3f);
            map1(PXBM_TX_IRC, r, n, r, {PXBM_PK_RDRSP, 1'b0, r, 2'h0, r, 5'h0}, 12'hd3f);
            map1(PXBM_TX_SRC, r, n, 1'b0, {PXBM_PK_RDRSP, 1'b0, r, 2'h0, r, 5'h0}, 12'hd3f);
            map1(PXBM_TX_SWC, r, n, 1'b0, {PXBM_PK_DONE, 4'h4, r, 5'h0}, 12'hd3f);
        end
        tx_cmpl_err <= 1'b0;
        tx_ecc_err <= 1'b1;
        tx_mode2 <= 1'b1;
        map1(PXBM_TX_PMW, 1'b0, 1'b0, 1'b0, {PXBM_PK_WRSZ, 7'h4c, 3'h0}, 12'hf7f);
        tx_ecc_err <= 1'b0;
        tx_mode2 <= 1'b0;
    endtask

    task automatic t_ctl();
        int b;
        ahb(1'b1, PXBM_A_CTRL, 32'h2);
        map1(PXBM_TX_SWC, 1'b0, 1'b0, 1'b1, {PXBM_PK_DONE, 4'h4, 6'h20}, 12'hd3f);
        ahb(1'b1, PXBM_A_CTRL, 32'h8);
        map1(PXBM_TX_SWC, 1'b0, 1'b0, 1'b1, {PXBM_PK_DONE, 4'h0, 6'h0}, 12'hd3f);
        ahb(1'b1, PXBM_A_CTRL, 32'h1);
        b = got_cnt;
        send(PXBM_TX_SWR, 1'b0, 1'b0, 1'b1, 4'hf);
        repeat (10) @(negedge sys_clk);
        chk("dropped", b, got_cnt);
        ahb(1'b1, PXBM_A_CTRL, 32'h4);
        map1(PXBM_TX_SRR, 1'b0, 1'b0, 1'b0, {PXBM_PK_RDSZ, 6'h04, 4'h5}, 12'hfff);
        ahb(1'b1, PXBM_A_CTRL, 32'h0);
    endtask

    // message: header packet, payload packet, closing packet
    task automatic t_dim();
        int b;
        b = got_cnt;
        {tx_msg_class, tx_route_type, tx_silent_drop, tx_init_req} <= 4'hb;
        tx_byte_count <= 12'h5a3;
        tx_requester_id <= 16'hbeef;
        tx_last <= 1'b0;
        send(PXBM_TX_DIM, 1'b0, 1'b0, 1'b0, 4'hf);
        wait_pk(b + 1);
        chk("dim_flags", {PXBM_PK_WRSZ, 6'h25, 4'h0}, got_flags & 12'hf7f);
        chk("dim_a52", 4'hb, got_addr[5:2]);
        chk("dim_a2724", 4'h5, got_addr[27:24]);
        chk("dim_data", 24'ha3beef, got_data[23:0]);
        tx_data <= 64'h0123456789abcdef;
        send(PXBM_TX_DIM, 1'b0, 1'b0, 1'b0, 4'hf);
        wait_pk(b + 2);
        chk("dim_chain", 1'b1, got_flags[4]);
        chk("dim_pay", 64'h0123456789abcdef, got_data);
        tx_last <= 1'b1;
        send(PXBM_TX_DIM, 1'b0, 1'b0, 1'b0, 4'hf);
        wait_pk(b + 3);
        chk("dim_chain", 1'b0, got_flags[4]);
        tx_last <= 1'b0;
    endtask

    // discontiguous enables: pieces ascending; config/io stays one doubleword
    task automatic t_split();
        int b;
        b = got_cnt;
        fork
            send(PXBM_TX_PMW, 1'b0, 1'b0, 1'b0, 4'h5);
            begin
                wait_pk(b + 1);
                chk("piece_be", 4'h1, got_be);
                wait_pk(b + 2);
                chk("piece_be", 4'h4, got_be);
            end
        join
        tx_cfg_io <= 1'b1;
        send(PXBM_TX_SWR, 1'b0, 1'b0, 1'b0, 4'h5);
        wait_pk(b + 3);
        chk("cfg_be", 4'h5, got_be);
        rel();
        tx_cfg_io <= 1'b0;
    endtask

    // response buffers: third request waits for a release
    task automatic t_buf();
        int b;
        b = got_cnt;
        send(PXBM_TX_SRR, 1'b0, 1'b0, 1'b0, 4'hf);
        send(PXBM_TX_SRR, 1'b0, 1'b0, 1'b0, 4'hf);
        present(PXBM_TX_SRR, 1'b0, 1'b0, 1'b0, 4'hf);
        refused();
        rel();
        accept();
        wait_pk(b + 3);
        repeat (3) rel();
    endtask

    // strict posted write blocks a later read; order kept on release
    task automatic t_ord();
        int b;
        b = got_cnt;
        stall <= 1'b1;
        send(PXBM_TX_PMW, 1'b0, 1'b0, 1'b0, 4'hf);
        present(PXBM_TX_SRR, 1'b0, 1'b0, 1'b0, 4'hf);
        refused();
        stall <= 1'b0;
        accept();
        wait_pk(b + 1);
        chk("first_kind", PXBM_PK_WRSZ, got_flags[11:10]);
        wait_pk(b + 2);
        chk("second_kind", PXBM_PK_RDSZ, got_flags[11:10]);
        rel();
    endtask

    // ********
    // main sequence and watchdog
    // ********
    initial begin
        {sys_clk, hsel, hwrite, tx_valid, stall, rsp_release} = '0;
        tx_kind = PXBM_TX_PMW;
        {haddr, htrans, hsize, hwdata, tx_relaxed, tx_no_snoop, tx_parity_err} = '0;
        {tx_ecc_err, tx_mode2, tx_cfg_io, tx_orig_resp_pass, tx_cmpl_err, tx_last} = '0;
        {tx_msg_class, tx_route_type, tx_silent_drop, tx_init_req, tx_byte_count} = '0;
        {tx_requester_id, tx_addr, tx_data, tx_byte_en} = '0;
        {error_cnt, tests_run} = '0;
        reset = 1'b1;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        t_reg();
        t_map();
        t_ctl();
        t_dim();
        t_split();
        t_buf();
        t_ord();
        wrap_up();
    end

    // the whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        wrap_up();
    end
endmodule
